// *** midi_router_pkg.sv ***
// Package with constants and types for the MIDI port router
`default_nettype none
package midi_router_pkg;
  localparam int BYTE_W = 8;
  localparam int NUM_SRC = 3;
  localparam int SRC_HOST = 0;
  localparam int SRC_DIN = 1;
  localparam int SRC_FOOT = 2;
  localparam logic [7:0] STATUS_MASK = 8'h80;
  localparam logic [7:0] RT_MIN = 8'hF8;
  localparam logic [7:0] BEAT_CLOCK = 8'hF8;
  localparam logic [7:0] SYSEX_END = 8'hF7;
  localparam logic [3:0] CC_NIBBLE = 4'hB;
  localparam logic [3:0] PC_NIBBLE = 4'hC;
  localparam logic [6:0] BANK_MSB_CC = 7'h00;
  localparam logic [6:0] BANK_LSB_CC = 7'h20;
  localparam int TICK_W = 32;
  localparam logic [1:0] ZERO_CNT = 2'h0;
  localparam logic [1:0] FULL_CNT = 2'h2;
  typedef enum logic [1:0] {
    MERGE_IDLE = 2'b00,
    MERGE_CORE = 2'b01,
    MERGE_FWD = 2'b10,
    MERGE_HOST = 2'b11
  } merge_state_t;
endpackage
`default_nettype wire

// *** byte_stream_if.sv ***
// Valid/ready byte stream interface used between router modules
`default_nettype none
interface byte_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** skid_buffer2.sv ***
// Two-entry valid/ready buffer so that a receiver stall loses no byte
`default_nettype none
module skid_buffer2 #(
  parameter int W = 8
) (
  input wire logic clk, // System clock
  input wire logic srst, // Synchronous reset, active high
  byte_stream_if.snk in_s, // Filling side
  byte_stream_if.src out_s // Draining side
);
  import midi_router_pkg::*;
  logic [W-1:0] mem [2];
  logic rd_ptr;
  logic wr_ptr;
  logic [1:0] count;
  logic push;
  logic pop;

  // Handshakes on both sides; full and empty come from the count
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;
  assign in_s.ready = (count != FULL_CNT);
  assign out_s.valid = (count != ZERO_CNT);
  assign out_s.data = mem[rd_ptr];

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_s.data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      count <= ZERO_CNT;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      if (push && !pop) begin
        count <= count + 2'h1;
      end else if (pop && !push) begin
        count <= count - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// *** midi_port_router_merge.sv ***
// MIDI router: broadcast, core delivery, thru and host-bridge merge, tempo and bank tracking
`default_nettype none
module midi_port_router_merge #(
  parameter int W = 8
) (
  input wire logic CLK_SYS, // 125 MHz system clock
  input wire logic SRST, // Synchronous reset, active high
  input wire logic THRU_EN, // Thru forwarding setting
  input wire logic BRIDGE_EN, // Host bridge setting
  input wire logic CORE_TX_VALID, // Core outbound byte valid
  input wire logic [midi_router_pkg::BYTE_W-1:0] CORE_TX_DATA, // Core outbound byte
  output logic CORE_TX_READY, // Core byte accepted
  input wire logic [midi_router_pkg::NUM_SRC-1:0] SRC_VALID, // Host, input port, foot port byte valid
  input wire logic [midi_router_pkg::NUM_SRC*midi_router_pkg::BYTE_W-1:0] SRC_DATA, // Source bytes
  output logic [midi_router_pkg::NUM_SRC-1:0] SRC_READY, // Source byte accepted
  output logic CORE_RX_VALID, // Inbound byte to core
  output logic [midi_router_pkg::BYTE_W-1:0] CORE_RX_DATA, // Inbound byte
  output logic [1:0] CORE_RX_SRC, // Which source it came from
  output logic OUT_VALID, // Output port byte valid
  output logic [midi_router_pkg::BYTE_W-1:0] OUT_DATA, // Output port byte
  input wire logic OUT_READY, // Output port takes byte
  output logic DIN_BACK_VALID, // Input-port back pins byte valid
  output logic [midi_router_pkg::BYTE_W-1:0] DIN_BACK_DATA, // Input-port back pins byte
  input wire logic DIN_BACK_READY, // Back pins take byte
  output logic FOOT_TX_VALID, // Foot port byte valid
  output logic [midi_router_pkg::BYTE_W-1:0] FOOT_TX_DATA, // Foot port byte
  input wire logic FOOT_TX_READY, // Foot port takes byte
  output logic HOST_IN_VALID, // Host virtual input byte valid
  output logic [midi_router_pkg::BYTE_W-1:0] HOST_IN_DATA, // Host virtual input byte
  input wire logic HOST_IN_READY, // Host takes byte
  output logic [midi_router_pkg::TICK_W-1:0] BEAT_PERIOD, // Cycles between beat clocks
  output logic BEAT_LOCKED, // At least two beat clocks seen
  output logic [13:0] BANK_VALUE, // Retained bank select
  output logic PROG_VALID, // Program change pulse
  output logic [20:0] PROG_NUMBER // Bank and program applied
);
  import midi_router_pkg::*;

  // Output port goes through the two-entry buffer
  byte_stream_if #(.W(BYTE_W)) out_in ();
  byte_stream_if #(.W(BYTE_W)) out_buf ();
  skid_buffer2 #(.W(BYTE_W)) u_out_buf (
    .clk(CLK_SYS),
    .srst(SRST),
    .in_s(out_in),
    .out_s(out_buf)
  );

  merge_state_t state;
  logic [1:0] rr;
  logic [BYTE_W-1:0] cur_src_byte;
  logic src_sel_valid;
  logic src_is_fwd;
  logic host_pending;
  logic take_src;
  logic take_core;
  logic bcast_free;
  logic core_msg_end;
  logic src_msg_end;
  logic [BYTE_W-1:0] src_byte [NUM_SRC];
  logic rx_free;
  logic host_room;

  for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
    assign src_byte[g] = SRC_DATA[g*BYTE_W +: BYTE_W];
  end

  // A forwarded message keeps the output until its source goes idle or sends a
  // real-time or end-of-exclusive byte; a gap in the owning stream stands in for
  // the end of a message, which is cheap but can cut a slow sender's message.
  assign rx_free = !CORE_RX_VALID;
  assign host_room = !HOST_IN_VALID || HOST_IN_READY;
  assign bcast_free = (!DIN_BACK_VALID || DIN_BACK_READY) && (!FOOT_TX_VALID || FOOT_TX_READY)
                      && host_room;
  assign cur_src_byte = src_byte[rr];
  assign src_sel_valid = SRC_VALID[rr];
  assign src_is_fwd = (rr == 2'(SRC_HOST)) ? BRIDGE_EN : THRU_EN;
  assign host_pending = (rr != 2'(SRC_HOST)) && BRIDGE_EN;
  // Real-time and end-of-exclusive bytes end a message; they do not cut into one another stream owns
  assign core_msg_end = (CORE_TX_DATA >= RT_MIN) || (CORE_TX_DATA == SYSEX_END);
  assign src_msg_end = (cur_src_byte >= RT_MIN) || (cur_src_byte == SYSEX_END);

  // Source byte is taken when core slot is free and all forwards have room
  // While a forward owns the output the core cannot send, so the host slot is free
  // to the owner; waiting on the core there would lock both sides up.
  assign take_src = src_sel_valid && rx_free
                    && (!src_is_fwd || (out_in.ready && state != MERGE_CORE))
                    && (!host_pending || (host_room && (!CORE_TX_VALID || state == MERGE_FWD)));
  // Core byte is broadcast when every destination has room and no source byte shares its slots
  assign take_core = CORE_TX_VALID && bcast_free && out_in.ready
                     && state != MERGE_FWD && state != MERGE_HOST
                     && !(take_src && (host_pending || src_is_fwd));
  assign SRC_READY = take_src ? (3'b001 << rr) : 3'b000;
  assign CORE_TX_READY = take_core;
  assign out_in.valid = take_core || (take_src && src_is_fwd);
  assign out_in.data = take_core ? CORE_TX_DATA : cur_src_byte;
  assign out_buf.ready = !OUT_VALID || OUT_READY;

  // Round robin over sources, held while a message from one is being forwarded
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      rr <= 2'h0;
    end else if ((!src_sel_valid || take_src) && !(take_src && src_is_fwd && !src_msg_end)) begin
      rr <= (rr == 2'(NUM_SRC - 1)) ? 2'h0 : rr + 2'h1;
    end
  end

  // Merge ownership: a stream keeps the output until its message ends or its stream goes idle
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      state <= MERGE_IDLE;
    end else begin
      case (state)
        MERGE_IDLE: begin
          if (take_core && !core_msg_end) begin
            state <= MERGE_CORE;
          end else if (take_src && src_is_fwd && !src_msg_end) begin
            state <= (rr == 2'(SRC_HOST)) ? MERGE_HOST : MERGE_FWD;
          end
        end
        MERGE_CORE: begin
          if (take_core && core_msg_end) begin
            state <= MERGE_IDLE;
          end else if (!CORE_TX_VALID) begin
            state <= MERGE_IDLE; // Core messages arrive whole; a gap ends one
          end
        end
        MERGE_FWD, MERGE_HOST: begin
          if (take_src && src_is_fwd && src_msg_end) begin
            state <= MERGE_IDLE;
          end else if (!src_sel_valid || !src_is_fwd) begin
            state <= MERGE_IDLE;
          end
        end
        default: state <= MERGE_IDLE;
      endcase
    end
  end

  // Registered destinations
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      OUT_VALID <= 1'b0;
      OUT_DATA <= '0;
      DIN_BACK_VALID <= 1'b0;
      DIN_BACK_DATA <= '0;
      FOOT_TX_VALID <= 1'b0;
      FOOT_TX_DATA <= '0;
      HOST_IN_VALID <= 1'b0;
      HOST_IN_DATA <= '0;
    end else begin
      if (out_buf.ready) begin
        OUT_VALID <= out_buf.valid;
        OUT_DATA <= out_buf.data;
      end
      if (take_core) begin
        DIN_BACK_VALID <= 1'b1;
        DIN_BACK_DATA <= CORE_TX_DATA;
        FOOT_TX_VALID <= 1'b1;
        FOOT_TX_DATA <= CORE_TX_DATA;
      end else begin
        if (DIN_BACK_READY) DIN_BACK_VALID <= 1'b0;
        if (FOOT_TX_READY) FOOT_TX_VALID <= 1'b0;
      end
      if (take_core) begin
        HOST_IN_VALID <= 1'b1;
        HOST_IN_DATA <= CORE_TX_DATA;
      end else if (take_src && host_pending) begin
        HOST_IN_VALID <= 1'b1;
        HOST_IN_DATA <= cur_src_byte;
      end else if (HOST_IN_READY) begin
        HOST_IN_VALID <= 1'b0;
      end
    end
  end

  // Core receive slot, fed from every source whatever the settings
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      CORE_RX_VALID <= 1'b0;
      CORE_RX_DATA <= '0;
      CORE_RX_SRC <= 2'h0;
    end else if (take_src) begin
      CORE_RX_VALID <= 1'b1;
      CORE_RX_DATA <= cur_src_byte;
      CORE_RX_SRC <= rr;
    end else begin
      CORE_RX_VALID <= 1'b0;
    end
  end

  // Beat-clock period measurement; follows the incoming rate with no setting
  logic [TICK_W-1:0] tick_cnt;
  logic seen_one;
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      tick_cnt <= '0;
      seen_one <= 1'b0;
      BEAT_PERIOD <= '0;
      BEAT_LOCKED <= 1'b0;
    end else if (take_src && cur_src_byte == BEAT_CLOCK) begin
      tick_cnt <= '0;
      seen_one <= 1'b1;
      if (seen_one) begin
        BEAT_PERIOD <= tick_cnt + TICK_W'(1);
        BEAT_LOCKED <= 1'b1;
      end
    end else if (tick_cnt != '1) begin
      tick_cnt <= tick_cnt + TICK_W'(1);
    end
  end

  // Bank select and program change tracking for inbound channel messages
  logic [BYTE_W-1:0] run_status;
  logic have_data1;
  logic [6:0] data1;
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      run_status <= '0;
      have_data1 <= 1'b0;
      data1 <= '0;
      BANK_VALUE <= '0;
      PROG_VALID <= 1'b0;
      PROG_NUMBER <= '0;
    end else begin
      PROG_VALID <= 1'b0;
      if (take_src && cur_src_byte < RT_MIN) begin
        if (cur_src_byte >= STATUS_MASK) begin
          run_status <= cur_src_byte;
          have_data1 <= 1'b0;
        end else if (run_status[7:4] == PC_NIBBLE) begin
          PROG_VALID <= 1'b1;
          PROG_NUMBER <= {BANK_VALUE, cur_src_byte[6:0]};
        end else if (run_status[7:4] == CC_NIBBLE) begin
          have_data1 <= !have_data1;
          data1 <= cur_src_byte[6:0];
          if (have_data1 && data1 == BANK_MSB_CC) begin
            BANK_VALUE[13:7] <= cur_src_byte[6:0];
          end else if (have_data1 && data1 == BANK_LSB_CC) begin
            BANK_VALUE[6:0] <= cur_src_byte[6:0];
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** midi_router_assertions.sv ***
// Concurrent checks on the ports of the MIDI port router
`default_nettype none
module midi_router_assertions (
  input wire logic CLK_SYS, // System clock
  input wire logic SRST, // Synchronous reset
  input wire logic BRIDGE_EN, // Host bridge setting
  input wire logic CORE_TX_VALID, // Core byte valid
  input wire logic [7:0] CORE_TX_DATA, // Core byte
  input wire logic CORE_TX_READY, // Core byte taken
  input wire logic [2:0] SRC_VALID, // Source valids
  input wire logic [23:0] SRC_DATA, // Source bytes
  input wire logic [2:0] SRC_READY, // Source grants
  input wire logic CORE_RX_VALID, // Inbound pulse
  input wire logic [7:0] CORE_RX_DATA, // Inbound byte
  input wire logic OUT_VALID, // Output port valid
  input wire logic [7:0] OUT_DATA, // Output port byte
  input wire logic OUT_READY, // Output port ready
  input wire logic FOOT_TX_VALID, // Foot port valid
  input wire logic [7:0] FOOT_TX_DATA, // Foot port byte
  input wire logic FOOT_TX_READY, // Foot port ready
  input wire logic HOST_IN_VALID, // Host input valid
  input wire logic [7:0] HOST_IN_DATA, // Host input byte
  input wire logic HOST_IN_READY, // Host input ready
  input wire logic DIN_BACK_VALID, // Back pins valid
  input wire logic [7:0] DIN_BACK_DATA // Back pins byte
);
  logic [7:0] sel;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  // Byte of the granted source, so the inbound pulse can be tied to it
  always_comb begin
    sel = 8'h00;
    for (int g = 0; g < 3; g++) if (SRC_READY[g]) sel = SRC_DATA[8*g +: 8];
  end
  sequence core_take;
    CORE_TX_VALID && CORE_TX_READY;
  endsequence
  sequence src_take;
    (SRC_VALID & SRC_READY) != 3'h0;
  endsequence
  chk_foot_copy: assert property (core_take |=> FOOT_TX_VALID && FOOT_TX_DATA == $past(CORE_TX_DATA))
    else $error("foot port missed a core byte");
  chk_din_copy: assert property (core_take |=> DIN_BACK_VALID && DIN_BACK_DATA == $past(CORE_TX_DATA))
    else $error("back pins missed a core byte");
  chk_host_copy: assert property (core_take |=> HOST_IN_VALID && HOST_IN_DATA == $past(CORE_TX_DATA))
    else $error("host input missed a core byte");
  chk_core_stall: assert property (CORE_TX_VALID && (FOOT_TX_VALID && !FOOT_TX_READY
    || HOST_IN_VALID && !HOST_IN_READY) |-> !CORE_TX_READY)
    else $error("core byte taken while a copy slot was full");
  chk_rx_deliver: assert property (src_take |=> CORE_RX_VALID && CORE_RX_DATA == $past(sel))
    else $error("inbound byte not delivered to core");
  chk_rx_spacing: assert property (CORE_RX_VALID |=> !CORE_RX_VALID)
    else $error("inbound pulses back to back");
  chk_grant_legal: assert property ($onehot0(SRC_READY) && (SRC_READY & ~SRC_VALID) == 3'h0)
    else $error("source grant not one-hot or without valid");
  chk_grant_gap: assert property (CORE_RX_VALID |-> SRC_READY == 3'h0)
    else $error("source granted during inbound pulse");
  chk_out_hold: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA))
    else $error("output port byte dropped under stall");
  chk_bridge_off: assert property (HOST_IN_VALID && $past(!HOST_IN_VALID || HOST_IN_READY) && !$past(BRIDGE_EN)
    |-> $past(CORE_TX_VALID && CORE_TX_READY))
    else $error("host input carried forwarded traffic with bridge off");
endmodule
bind midi_port_router_merge midi_router_assertions i_chk (.*);
`default_nettype wire

// *** midi_far_side.sv ***
// Far-side sinks: output port, back pins, foot port and host input
`default_nettype none
module midi_far_side (
  input wire logic [3:0] stall, // Per-sink stall request from the bench
  output logic out_ready, // Output port sink
  output logic din_ready, // Back pins sink
  output logic foot_ready, // Foot port sink
  output logic host_ready // Host input sink
);
  // Sinks take bytes promptly unless told to stall, so slow receivers are exercised
  assign {host_ready, foot_ready, din_ready, out_ready} = ~stall;
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the MIDI port router with a queue-based reference model
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import midi_router_pkg::*;
  logic CLK_SYS = 1'b0, SRST = 1'b1, THRU_EN = 1'b0, BRIDGE_EN = 1'b0, CORE_TX_VALID = 1'b0, CORE_TX_READY;
  logic [7:0] CORE_TX_DATA = 8'h00, CORE_RX_DATA, OUT_DATA, DIN_BACK_DATA, FOOT_TX_DATA, HOST_IN_DATA;
  logic [2:0] SRC_VALID = 3'h0, SRC_READY;
  logic [23:0] SRC_DATA = 24'h0;
  logic CORE_RX_VALID, OUT_VALID, DIN_BACK_VALID, FOOT_TX_VALID, HOST_IN_VALID, BEAT_LOCKED, PROG_VALID;
  logic OUT_READY, DIN_BACK_READY, FOOT_TX_READY, HOST_IN_READY;
  logic [1:0] CORE_RX_SRC;
  logic [31:0] BEAT_PERIOD, seed = 32'h31;
  logic [13:0] BANK_VALUE;
  logic [20:0] PROG_NUMBER;
  logic [3:0] stall = 4'h0, held = 4'h0;
  logic [7:0] eq [5][4][$]; // Expected bytes per destination and origin
  logic [7:0] script [4][$]; // Bytes to send: core, host, input port, foot port
  int failures = 0, cmp_count = 0, cyc = 0, last_beat = -1, exp_period = 0, progs = 0;
  int rxq [$]; // Origin of each byte owed to the core, in order
  logic [7:0] last_src = 8'h00; // Last source byte taken, for the program number
  always #4 CLK_SYS = ~CLK_SYS;
  midi_port_router_merge i_dut (.*);
  midi_far_side i_far (.stall(stall), .out_ready(OUT_READY), .din_ready(DIN_BACK_READY),
    .foot_ready(FOOT_TX_READY), .host_ready(HOST_IN_READY));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic int left();
    int s = 0;
    foreach (eq[d, o]) s += eq[d][o].size();
    foreach (script[k]) s += script[k].size();
    return s;
  endfunction
  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Merged streams may interleave, so a byte may match the head of any origin
  task automatic take(input int d, input string name, input logic [7:0] got);
    int o = -1;
    for (int k = 0; k < 4; k++)
      if (eq[d][k].size() > 0 && (o < 0 || eq[d][k][0] === got)) o = k;
    check_word(name, (o < 0) ? 32'hXX : eq[d][o].pop_front(), got);
  endtask
  task automatic drain();
    repeat (3000) if (left() != 0) @(posedge CLK_SYS);
    check_word("leftover", 0, left());
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Reference model: observe every accepted byte and every delivered byte
  always @(posedge CLK_SYS) begin
    cyc++;
    if (!SRST) begin
      if (FOOT_TX_VALID && FOOT_TX_READY) take(0, "foot", FOOT_TX_DATA);
      if (DIN_BACK_VALID && DIN_BACK_READY) take(1, "din_back", DIN_BACK_DATA);
      if (HOST_IN_VALID && HOST_IN_READY) take(2, "host_in", HOST_IN_DATA);
      if (OUT_VALID && OUT_READY) take(3, "out", OUT_DATA);
      if (CORE_RX_VALID) take(4, "core_rx", CORE_RX_DATA);
      if (CORE_RX_VALID) check_word("core_rx_src", (rxq.size() > 0) ? rxq.pop_front() : -1, CORE_RX_SRC);
      if (PROG_VALID) progs++;
      if (PROG_VALID) check_word("prog_bank", 32'h82, PROG_NUMBER[20:7]);
      if (PROG_VALID) check_word("prog_number", {11'h0, 14'h82, last_src[6:0]}, PROG_NUMBER);
      if (CORE_TX_VALID && CORE_TX_READY) begin
        for (int d = 0; d < 4; d++) eq[d][0].push_back(CORE_TX_DATA);
        void'(script[0].pop_front());
        held[0] = 1'b0;
      end
      for (int g = 0; g < 3; g++) if (SRC_VALID[g] && SRC_READY[g]) begin
        eq[4][g+1].push_back(SRC_DATA[8*g +: 8]);
        rxq.push_back(g);
        last_src = SRC_DATA[8*g +: 8];
        if (g == 0 ? BRIDGE_EN : THRU_EN) eq[3][g+1].push_back(SRC_DATA[8*g +: 8]);
        if (g > 0 && BRIDGE_EN) eq[2][g+1].push_back(SRC_DATA[8*g +: 8]);
        if (SRC_DATA[8*g +: 8] === BEAT_CLOCK) begin
          if (last_beat >= 0) exp_period = cyc - last_beat;
          last_beat = cyc;
        end
        void'(script[g+1].pop_front());
        held[g+1] = 1'b0;
      end
    end
  end
  // Drivers hold a byte until taken; random gaps and sink stalls between bytes
  always @(negedge CLK_SYS) begin
    seed = xs(seed);
    stall = seed[7:4] & seed[11:8];
    for (int s = 0; s < 4; s++) held[s] = script[s].size() > 0 && (held[s] || seed[s+12]);
    CORE_TX_VALID = held[0];
    CORE_TX_DATA = held[0] ? script[0][0] : 8'h00;
    SRC_VALID = held[3:1];
    for (int g = 0; g < 3; g++) SRC_DATA[8*g +: 8] = held[g+1] ? script[g+1][0] : 8'h00;
  end
  initial begin
    #400000;
    failures++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge CLK_SYS);
    @(negedge CLK_SYS) SRST = 1'b0;
    // Bank select, then two program changes: the second must reuse the retained bank
    script[1] = '{8'hB0, 8'h00, 8'h01, 8'hB0, 8'h20, 8'h02, 8'hC0, 8'h05, 8'hC0, 8'h07};
    drain();
    check_word("bank", 32'h82, BANK_VALUE);
    check_word("prog_count", 2, progs);
    // Beat clocks with changing spacing; period must follow the latest pair
    for (int k = 0; k < 3; k++) begin
      script[2].push_back(BEAT_CLOCK);
      drain();
      repeat (20 + 7 * k) @(posedge CLK_SYS);
    end
    check_word("beat_period", exp_period, BEAT_PERIOD);
    check_word("beat_locked", 1, BEAT_LOCKED);
    // Random traffic on all streams under every setting combination
    for (int m = 0; m < 8; m++) begin
      @(negedge CLK_SYS);
      {BRIDGE_EN, THRU_EN} = m[1:0];
      for (int k = 0; k < 4; k++) repeat (40) begin
        seed = xs(seed);
        script[k].push_back(seed[7:0] & 8'h7F);
      end
      drain();
    end
    summarize();
  end
endmodule
`default_nettype wire
